// ===== hdl/clock_sysref_pkg.sv
package clock_sysref_pkg;
  // register addresses on the serial port
  localparam logic [14:0] ADDR_CTRL0 = 15'h0029;
  localparam logic [14:0] ADDR_CTRL1 = 15'h002a;
  localparam logic [14:0] ADDR_CTRL2 = 15'h002b;
  localparam logic [14:0] ADDR_POS0 = 15'h002c;
  localparam logic [14:0] ADDR_POS1 = 15'h002d;
  localparam logic [14:0] ADDR_POS2 = 15'h002e;
  localparam logic [14:0] ADDR_FSA_LO = 15'h0030;
  localparam logic [14:0] ADDR_FSA_HI = 15'h0031;
  localparam logic [14:0] ADDR_FSB_LO = 15'h0032;
  localparam logic [14:0] ADDR_FSB_HI = 15'h0033;
  // reset values
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h11;
  localparam logic [15:0] RST_FS = 16'ha000;
  localparam logic [23:0] RST_POS = 24'h000000;
  // clock_control_zero fields
  localparam int CTRL0_SEL_LSB = 0;
  localparam int CTRL0_FINE = 4;
  localparam int CTRL0_RECV = 5;
  localparam int CTRL0_PROC = 6;
  // clock_control_one fields
  localparam int CTRL1_FLIP = 0;
  localparam int CTRL1_SR_DC = 1;
  localparam int CTRL1_DEV_DC = 2;
  localparam int CTRL1_STAMP = 3;
  // clock_control_two fields
  localparam int CTRL2_DLY_LSB = 0;
  localparam int CTRL2_NOISE = 2;
  localparam int CTRL2_GAIN = 4;
  // frame layout
  localparam logic [4:0] HDR_BITS = 5'd16;
  localparam logic [2:0] BYTE_LAST = 3'd7;
  localparam int SAMPLE_W = 12;
  localparam int POS_W = 24;
endpackage

// ===== hdl/sysref_cfg_if.sv
`timescale 1ns/100ps
interface sysref_cfg_if;
  logic polarity_flip; // invert sysref
  logic fine_step; // finer position steps
  logic stamp_enable; // sysref as timestamp
  logic [23:0] edge_position; // captured window
  logic edge_seen; // an edge was captured
  modport regs (output polarity_flip, output fine_step, output stamp_enable,
                input edge_position, input edge_seen);
  modport path (input polarity_flip, input fine_step, input stamp_enable,
                output edge_position, output edge_seen);
endinterface

// ===== hdl/sysref_monitor.sv
`timescale 1ns/100ps
module sysref_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // sysref pin, asynchronous
  input wire logic i_sysref,
  // sample path
  input wire logic [11:0] i_sample_data,
  input wire logic i_sample_valid,
  input wire logic i_marker_insert_enable,
  input wire logic i_decim_bypass,
  output logic [11:0] o_sample_data,
  output logic o_sample_valid,
  // register side
  sysref_cfg_if.path cfg
);
  logic [1:0] sync_q; // pin synchroniser
  logic level_q; // aligned level, after polarity
  logic prev_q; // for edge detect
  logic div_q; // coarse step divider
  logic [23:0] hist_q; // sampled history
  logic [23:0] pos_q; // captured position
  logic seen_q; // capture flag
  logic step; // history shift enable
  logic stamp_on; // insertion allowed

  // two flops before any logic reads the pin
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sync_q <= 2'h0;
    else
      sync_q <= {sync_q[0], i_sysref};
  end

  // polarity applied before alignment use
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      level_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      level_q <= sync_q[1] ^ cfg.polarity_flip;
      prev_q <= level_q;
    end
  end

  // fine step shifts every cycle, coarse every second
  assign step = cfg.fine_step | div_q;

  // divider for the coarse step enable
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      div_q <= 1'b0;
    else
      div_q <= ~div_q;
  end

  // history window and capture on rising edge
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      hist_q <= clock_sysref_pkg::RST_POS;
      pos_q <= clock_sysref_pkg::RST_POS;
      seen_q <= 1'b0;
    end
    else
    begin
      if (step)
        hist_q <= {hist_q[22:0], level_q};
      if (level_q && !prev_q)
      begin
        pos_q <= hist_q;
        seen_q <= 1'b1;
      end
    end
  end

  assign cfg.edge_position = pos_q;
  assign cfg.edge_seen = seen_q;

  // stamping only with decimation bypassed
  assign stamp_on = cfg.stamp_enable & i_marker_insert_enable & i_decim_bypass;

  // lsb replaced by sysref level when stamping
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_sample_data <= 12'h000;
      o_sample_valid <= 1'b0;
    end
    else
    begin
      o_sample_valid <= i_sample_valid;
      if (stamp_on)
        o_sample_data <= {i_sample_data[11:1], level_q};
      else
        o_sample_data <= i_sample_data;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  stamp_lsb_a: assert property (stamp_on |=> o_sample_data[0] == $past(level_q))
    else $error("stamp lsb not sysref level");
  no_stamp_decim_a: assert property (!i_decim_bypass |=> o_sample_data == $past(i_sample_data))
    else $error("stamp applied while decimating");
  polarity_flip_a: assert property (##1 level_q == ($past(sync_q[1]) ^ $past(cfg.polarity_flip)))
    else $error("sysref polarity wrong");
  edge_capture_a: assert property (level_q && !prev_q |=> seen_q && pos_q == $past(hist_q))
    else $error("edge position not captured");
  coarse_hold_a: assert property (!cfg.fine_step && !div_q |=> hist_q == $past(hist_q))
    else $error("coarse step shifted early");
  stamp_seen_c: cover property (stamp_on && level_q);
  edge_seen_c: cover property (level_q && !prev_q && cfg.fine_step);
endmodule

// ===== hdl/clock_sysref_fullscale_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - stamp plus marker enable puts sysref in lsb
// - stamping only when decimation is bypassed
// - polarity bit inverts sysref for alignment
// - ctrl1 bits 2,1 select dc coupling
// - ctrl2 resets 0x11, bit 4 high gain
// - ctrl2 bit 2 enables supply noise suppression
// - sample delay field one-hot, resets 0x1; writes take any 2-bit value
// - 24-bit edge position status reported
// - fullscale a at 0x30, resets 0xa000
// - fullscale b at 0x32, resets 0xa000
// - ctrl2 at 0x2b, position at 0x2c
// - fine step gives finer position resolution
module clock_sysref_fullscale_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // serial configuration port
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  // sysref pin and sample path
  input wire logic i_sysref,
  input wire logic [11:0] i_sample_data,
  input wire logic i_sample_valid,
  input wire logic i_marker_insert_enable,
  input wire logic i_decim_bypass,
  output logic [11:0] o_sample_data,
  output logic o_sample_valid,
  // clock and sysref controls
  output logic o_devclock_dc_couple_enable,
  output logic o_sysref_dc_couple_enable,
  output logic o_feedback_gain_high,
  output logic o_supply_noise_suppress,
  output logic [1:0] o_sample_clock_delay,
  output logic [3:0] o_sysref_delay_select,
  output logic o_sysref_receiver_enable,
  output logic o_sysref_processor_enable,
  // fullscale codes
  output logic [15:0] o_fullscale_code_a,
  output logic [15:0] o_fullscale_code_b
);
  // port frame states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_DATA = 2'b10
  } frame_st_t;

  // pin synchronisers, stage 1 read by stage 2 only
  logic [2:0] s1_q; // sclk, cs_n, sdi first stage
  logic [2:0] s2_q; // second stage
  logic sclk_d1_q; // sclk delayed, edge detect
  logic sclk_rise; // sclk rising edge
  logic sclk_fall; // sclk falling edge
  logic cs_act; // chip select asserted
  logic sdi_s; // synchronised data in

  // frame state
  frame_st_t st_q; // frame phase
  logic [4:0] hcnt_q; // header bits taken
  logic [2:0] bcnt_q; // bits within data byte
  logic [15:0] hdr_q; // rw plus address
  logic [6:0] sh_q; // write data shift
  logic rd_q; // frame is a read
  logic [14:0] addr_q; // current byte address
  logic [7:0] tx_q; // read data shift
  logic sdo_q; // serial out
  logic oe_q; // serial out enable
  logic wr_stb; // a write byte completed
  logic [7:0] wr_byte; // byte just written
  logic hdr_done; // header completed this edge

  // register storage
  logic [7:0] ctrl0_q; // clock_control_zero
  logic [7:0] ctrl1_q; // clock_control_one
  logic [7:0] ctrl2_q; // clock_control_two
  logic [15:0] fsa_q; // fullscale_code_a
  logic [15:0] fsb_q; // fullscale_code_b

  sysref_cfg_if cfg_if ();

  // read decode shared by header and byte reload
  function automatic logic [7:0] read_byte(input logic [14:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      clock_sysref_pkg::ADDR_CTRL0: r = ctrl0_q;
      clock_sysref_pkg::ADDR_CTRL1: r = ctrl1_q;
      clock_sysref_pkg::ADDR_CTRL2: r = ctrl2_q;
      clock_sysref_pkg::ADDR_POS0: r = cfg_if.edge_position[7:0];
      clock_sysref_pkg::ADDR_POS1: r = cfg_if.edge_position[15:8];
      clock_sysref_pkg::ADDR_POS2: r = cfg_if.edge_position[23:16];
      clock_sysref_pkg::ADDR_FSA_LO: r = fsa_q[7:0];
      clock_sysref_pkg::ADDR_FSA_HI: r = fsa_q[15:8];
      clock_sysref_pkg::ADDR_FSB_LO: r = fsb_q[7:0];
      clock_sysref_pkg::ADDR_FSB_HI: r = fsb_q[15:8];
      default: r = 8'h00; // unmapped reads zero
    endcase
    return r;
  endfunction

  // two flops on every port pin
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s1_q <= 3'h2;
      s2_q <= 3'h2;
    end
    else
    begin
      s1_q <= {i_spi_sclk, i_spi_cs_n, i_spi_sdi};
      s2_q <= s1_q;
    end
  end

  // sclk history for edges
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sclk_d1_q <= 1'b0;
    else
      sclk_d1_q <= s2_q[2];
  end

  assign cs_act = ~s2_q[1];
  assign sdi_s = s2_q[0];
  assign sclk_rise = cs_act & s2_q[2] & ~sclk_d1_q;
  assign sclk_fall = cs_act & ~s2_q[2] & sclk_d1_q;
  assign hdr_done = (st_q == ST_HDR) && sclk_rise && (hcnt_q == clock_sysref_pkg::HDR_BITS - 5'd1);
  assign wr_stb = (st_q == ST_DATA) && sclk_rise && !rd_q && (bcnt_q == clock_sysref_pkg::BYTE_LAST);
  assign wr_byte = {sh_q, sdi_s};

  // frame sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !cs_act)
    begin
      st_q <= ST_IDLE;
      hcnt_q <= 5'd0;
      bcnt_q <= 3'd0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          st_q <= ST_HDR; // frame opened
        end
        ST_HDR:
        begin
          if (sclk_rise)
            hcnt_q <= hcnt_q + 5'd1;
          if (hdr_done)
            st_q <= ST_DATA;
        end
        ST_DATA:
        begin
          if (sclk_rise)
            bcnt_q <= bcnt_q + 3'd1; // wraps per byte
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // header and write data shifting
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      hdr_q <= 16'h0000;
      sh_q <= 7'h00;
    end
    else if (sclk_rise)
    begin
      if (st_q == ST_HDR)
        hdr_q <= {hdr_q[14:0], sdi_s};
      else
        sh_q <= {sh_q[5:0], sdi_s};
    end
  end

  // address and direction, ascending stream
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rd_q <= 1'b0;
      addr_q <= 15'h0000;
    end
    else if (hdr_done)
    begin
      rd_q <= hdr_q[14];
      addr_q <= {hdr_q[13:0], sdi_s};
    end
    else if ((st_q == ST_DATA) && sclk_rise && (bcnt_q == clock_sysref_pkg::BYTE_LAST))
      addr_q <= addr_q + 15'h0001;
  end

  // read shifter: load on rise, shift out on fall
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !cs_act)
    begin
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      if (hdr_done)
      begin
        tx_q <= read_byte({hdr_q[13:0], sdi_s});
        oe_q <= hdr_q[14];
      end
      else if ((st_q == ST_DATA) && rd_q && sclk_rise && (bcnt_q == clock_sysref_pkg::BYTE_LAST))
        tx_q <= read_byte(addr_q + 15'h0001);
      else if ((st_q == ST_DATA) && rd_q && sclk_fall)
      begin
        sdo_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // clock_control_zero and one
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl0_q <= clock_sysref_pkg::RST_CTRL0;
      ctrl1_q <= clock_sysref_pkg::RST_CTRL1;
    end
    else if (wr_stb)
    begin
      if (addr_q == clock_sysref_pkg::ADDR_CTRL0)
        ctrl0_q <= wr_byte;
      if (addr_q == clock_sysref_pkg::ADDR_CTRL1)
        ctrl1_q <= wr_byte;
    end
  end

  // clock_control_two, all bits writable
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ctrl2_q <= clock_sysref_pkg::RST_CTRL2;
    else if (wr_stb && addr_q == clock_sysref_pkg::ADDR_CTRL2)
      ctrl2_q <= wr_byte;
  end

  // fullscale codes, low byte at even address
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      fsa_q <= clock_sysref_pkg::RST_FS;
      fsb_q <= clock_sysref_pkg::RST_FS;
    end
    else if (wr_stb)
    begin
      case (addr_q)
        clock_sysref_pkg::ADDR_FSA_LO: fsa_q[7:0] <= wr_byte;
        clock_sysref_pkg::ADDR_FSA_HI: fsa_q[15:8] <= wr_byte;
        clock_sysref_pkg::ADDR_FSB_LO: fsb_q[7:0] <= wr_byte;
        clock_sysref_pkg::ADDR_FSB_HI: fsb_q[15:8] <= wr_byte;
        default: ; // position writes dropped
      endcase
    end
  end

  // register fields onto the sysref path
  assign cfg_if.polarity_flip = ctrl1_q[clock_sysref_pkg::CTRL1_FLIP];
  assign cfg_if.fine_step = ctrl0_q[clock_sysref_pkg::CTRL0_FINE];
  assign cfg_if.stamp_enable = ctrl1_q[clock_sysref_pkg::CTRL1_STAMP];

  sysref_monitor u_sysref (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sysref(i_sysref),
    .i_sample_data(i_sample_data),
    .i_sample_valid(i_sample_valid),
    .i_marker_insert_enable(i_marker_insert_enable),
    .i_decim_bypass(i_decim_bypass),
    .o_sample_data(o_sample_data),
    .o_sample_valid(o_sample_valid),
    .cfg(cfg_if.path)
  );

  // outputs straight from register flops
  assign o_spi_sdo = sdo_q;
  assign o_spi_sdo_oe = oe_q;
  assign o_devclock_dc_couple_enable = ctrl1_q[clock_sysref_pkg::CTRL1_DEV_DC];
  assign o_sysref_dc_couple_enable = ctrl1_q[clock_sysref_pkg::CTRL1_SR_DC];
  assign o_feedback_gain_high = ctrl2_q[clock_sysref_pkg::CTRL2_GAIN];
  assign o_supply_noise_suppress = ctrl2_q[clock_sysref_pkg::CTRL2_NOISE];
  assign o_sample_clock_delay = ctrl2_q[clock_sysref_pkg::CTRL2_DLY_LSB +: 2];
  assign o_sysref_delay_select = ctrl0_q[clock_sysref_pkg::CTRL0_SEL_LSB +: 4];
  assign o_sysref_receiver_enable = ctrl0_q[clock_sysref_pkg::CTRL0_RECV];
  assign o_sysref_processor_enable = ctrl0_q[clock_sysref_pkg::CTRL0_PROC];
  assign o_fullscale_code_a = fsa_q;
  assign o_fullscale_code_b = fsb_q;

  default clocking cb @(posedge i_clk); endclocking

  ctrl2_reset_a: assert property (i_sys_rst |=> ctrl2_q == 8'h11 && o_feedback_gain_high)
    else $error("ctrl2 reset value wrong");
  delay_onehot_a: assert property (i_sys_rst |=> o_sample_clock_delay == 2'h1)
    else $error("sample delay reset not one-hot");
  dc_reset_a: assert property (i_sys_rst |=> !o_devclock_dc_couple_enable && !o_sysref_dc_couple_enable)
    else $error("dc couple bits not cleared");
  noise_reset_a: assert property (i_sys_rst |=> !o_supply_noise_suppress)
    else $error("noise suppress not cleared");
  fs_reset_a: assert property (i_sys_rst |=> fsa_q == 16'ha000 && fsb_q == 16'ha000)
    else $error("fullscale reset wrong");
  fsb_write_a: assert property (disable iff (i_sys_rst)
    wr_stb && addr_q == 15'h0032 |=> o_fullscale_code_b[7:0] == $past(wr_byte))
    else $error("fullscale b low byte not written");
  ctrl2_write_a: assert property (disable iff (i_sys_rst)
    wr_stb && addr_q == 15'h002b |=> ctrl2_q == $past(wr_byte))
    else $error("ctrl2 write lost");
  pos_ro_a: assert property (disable iff (i_sys_rst)
    wr_stb && addr_q == 15'h002c |=> $stable(ctrl0_q) && $stable(ctrl2_q) && $stable(fsa_q))
    else $error("position write disturbed registers");
  pos_read_a: assert property (disable iff (i_sys_rst)
    hdr_done && {hdr_q[14:0], sdi_s} == 16'h802c |=> tx_q == $past(cfg_if.edge_position[7:0]))
    else $error("position read wrong");
  pos_seen_a: assert property (disable iff (i_sys_rst)
    !cfg_if.edge_seen |-> cfg_if.edge_position == clock_sysref_pkg::RST_POS)
    else $error("position set before any capture");
  oe_read_a: assert property (disable iff (i_sys_rst) o_spi_sdo_oe |-> rd_q && st_q == ST_DATA)
    else $error("sdo driven outside read");
  write_c: cover property (wr_stb && addr_q == clock_sysref_pkg::ADDR_FSA_HI);
  read_c: cover property (hdr_done && hdr_q[14]);
  stream_c: cover property (wr_stb ##[1:300] wr_stb);
endmodule

// ===== tb/spi_host_model.sv
`timescale 1ns/100ps
// serial configuration host: cs_n framed, sclk idle low, msb first
module spi_host_model (
  // clock
  input wire logic i_clk,
  // serial port pins
  input wire logic i_spi_sdo,
  output logic o_spi_sclk,
  output logic o_spi_cs_n,
  output logic o_spi_sdi
);
  // idle levels from time zero
  initial
  begin
    o_spi_sclk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_sdi = 1'b0;
  end

  // one sclk phase, long enough for the device's two-flop sync
  task automatic half();
    repeat (6) @(posedge i_clk);
    #1;
  endtask

  // one bit: data set in the low phase, read data taken at the rise
  task automatic one_bit(input logic d, output logic q);
    o_spi_sdi = d;
    half();
    o_spi_sclk = 1'b1;
    q = i_spi_sdo;
    half();
    o_spi_sclk = 1'b0;
  endtask

  // whole frame: header, then byte k at address addr+k
  task automatic frame(input logic rd, input logic [14:0] addr, input int nbytes,
                       input logic [31:0] wdata, output logic [31:0] rdata);
    logic [15:0] hdr;
    logic q;
    logic d;
    hdr = {rd, addr};
    rdata = 32'h0;
    d = 1'b0;
    o_spi_cs_n = 1'b0;
    half();
    for (int i = 15; i >= 0; i--)
      one_bit(hdr[i], q);
    for (int k = 0; k < nbytes; k++)
      for (int i = 7; i >= 0; i--)
      begin
        // read phase: sdi toggles and carries nothing
        d = rd ? ~d : wdata[8*k+i];
        one_bit(d, q);
        rdata[8*k+i] = q;
      end
    half();
    o_spi_cs_n = 1'b1;
    // a released line does not keep its last value
    o_spi_sdi = ~o_spi_sdi;
    half();
  endtask
endmodule

// ===== tb/test_clock_sysref_fullscale_regs.sv
`timescale 1ns/100ps
// register bank bench: sequences of serial frames with expected values
module test_clock_sysref_fullscale_regs;
  // clock and reset
  logic i_clk;
  logic i_sys_rst;
  // serial pins
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic sdo_line;
  logic idle_pat;
  // sysref and sample path
  logic sysref;
  logic [11:0] sample_in;
  logic sample_in_valid;
  logic marker_en;
  logic bypass;
  logic [11:0] sample_out;
  logic sample_out_valid;
  // control outputs
  logic devclk_dc;
  logic sysref_dc;
  logic gain_high;
  logic noise_sup;
  logic [1:0] clk_delay;
  logic [3:0] delay_sel;
  logic recv_en;
  logic proc_en;
  logic [15:0] fs_a;
  logic [15:0] fs_b;
  // counters
  int num_errors = 0;
  int samples_checked = 0;

  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // released sdo shows a changing pattern, not the last bit
  initial idle_pat = 1'b0;
  always @(posedge i_clk) idle_pat <= ~idle_pat;
  assign sdo_line = spi_sdo_oe ? spi_sdo : idle_pat;

  // device under test
  clock_sysref_fullscale_regs clock_sysref_fullscale_regs_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_spi_sclk(spi_sclk), .i_spi_cs_n(spi_cs_n), .i_spi_sdi(spi_sdi),
    .o_spi_sdo(spi_sdo), .o_spi_sdo_oe(spi_sdo_oe),
    .i_sysref(sysref), .i_sample_data(sample_in), .i_sample_valid(sample_in_valid),
    .i_marker_insert_enable(marker_en), .i_decim_bypass(bypass),
    .o_sample_data(sample_out), .o_sample_valid(sample_out_valid),
    .o_devclock_dc_couple_enable(devclk_dc), .o_sysref_dc_couple_enable(sysref_dc),
    .o_feedback_gain_high(gain_high), .o_supply_noise_suppress(noise_sup),
    .o_sample_clock_delay(clk_delay), .o_sysref_delay_select(delay_sel),
    .o_sysref_receiver_enable(recv_en), .o_sysref_processor_enable(proc_en),
    .o_fullscale_code_a(fs_a), .o_fullscale_code_b(fs_b)
  );

  // host on the serial port
  spi_host_model spi_host_model_inst (
    .i_clk(i_clk), .i_spi_sdo(sdo_line),
    .o_spi_sclk(spi_sclk), .o_spi_cs_n(spi_cs_n), .o_spi_sdi(spi_sdi)
  );

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // register write and read frames
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    logic [31:0] junk;
    spi_host_model_inst.frame(1'b0, a, n, d, junk);
  endtask
  task automatic rd(input logic [14:0] a, input int n, output logic [31:0] q);
    spi_host_model_inst.frame(1'b1, a, n, 32'h0, q);
  endtask

  // wait n cycles, land just after the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // periodic sysref pulses, 3 high 7 low, then quiet
  task automatic pulses(input int n);
    repeat (n)
    begin
      sysref = 1'b1;
      wait_clk(3);
      sysref = 1'b0;
      wait_clk(7);
    end
    wait_clk(40);
  endtask

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (80000) @(posedge i_clk);
    num_errors++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    logic [31:0] q;
    logic [31:0] pos_fine;
    logic [31:0] pos_coarse;
    i_sys_rst = 1'b1;
    sysref = 1'b0;
    sample_in = 12'h5a4;
    sample_in_valid = 1'b1;
    marker_en = 1'b0;
    bypass = 1'b1;
    wait_clk(16);
    i_sys_rst = 1'b0;
    wait_clk(4);
    // reset values of the bank
    rd(clock_sysref_pkg::ADDR_CTRL0, 3, q);
    check(q, 32'h00110000);
    rd(clock_sysref_pkg::ADDR_POS0, 3, q);
    check(q, 32'h0);
    rd(clock_sysref_pkg::ADDR_FSA_LO, 4, q);
    check(q, 32'ha000a000);
    check(32'({gain_high, noise_sup, clk_delay}), 32'h9);
    check(32'({fs_a, fs_b}), 32'ha000a000);
    // clock control two: suppression on, one-hot delays only
    wr(clock_sysref_pkg::ADDR_CTRL2, 1, 32'h06);
    check(32'({gain_high, noise_sup, clk_delay}), 32'h6);
    wr(clock_sysref_pkg::ADDR_CTRL2, 1, 32'h15);
    check(32'({gain_high, noise_sup, clk_delay}), 32'hd);
    rd(clock_sysref_pkg::ADDR_CTRL2, 1, q);
    check(q, 32'h15);
    // dc coupling bits one at a time
    wr(clock_sysref_pkg::ADDR_CTRL1, 1, 32'h04);
    check(32'({devclk_dc, sysref_dc}), 32'h2);
    wr(clock_sysref_pkg::ADDR_CTRL1, 1, 32'h02);
    check(32'({devclk_dc, sysref_dc}), 32'h1);
    // fullscale codes at the recommended minimum and the maximum
    wr(clock_sysref_pkg::ADDR_FSA_LO, 4, 32'hffff2000);
    check(32'({fs_a, fs_b}), 32'h2000ffff);
    rd(clock_sysref_pkg::ADDR_FSA_LO, 4, q);
    check(q, 32'hffff2000);
    // unmapped place: write ignored, reads zero
    wr(15'h0034, 1, 32'h5a);
    rd(15'h0034, 1, q);
    check(q, 32'h0);
    // sysref stamped into the lsb with all three enables, not without marker enable or bypass
    wr(clock_sysref_pkg::ADDR_CTRL1, 1, 32'h08);
    marker_en = 1'b1;
    sysref = 1'b1;
    wait_clk(10);
    check(32'({sample_out_valid, sample_out}), 32'h15a5);
    bypass = 1'b0;
    wait_clk(4);
    check(32'(sample_out), 32'h5a4);
    bypass = 1'b1;
    marker_en = 1'b0;
    wait_clk(4);
    check(32'(sample_out), 32'h5a4);
    marker_en = 1'b1;
    wr(clock_sysref_pkg::ADDR_CTRL1, 1, 32'h09);
    wait_clk(10);
    check(32'(sample_out), 32'h5a4);
    sysref = 1'b0;
    wait_clk(10);
    check(32'(sample_out), 32'h5a5);
    // edge position with fine steps
    wr(clock_sysref_pkg::ADDR_CTRL1, 1, 32'h00);
    wr(clock_sysref_pkg::ADDR_CTRL0, 1, 32'h10);
    pulses(6);
    rd(clock_sysref_pkg::ADDR_POS0, 3, pos_fine);
    check(32'(pos_fine != 32'h0), 32'h1);
    wr(clock_sysref_pkg::ADDR_POS0, 3, 32'hffffff);
    rd(clock_sysref_pkg::ADDR_POS0, 3, q);
    check(q, pos_fine);
    // coarse steps give another snapshot of the same pattern
    wr(clock_sysref_pkg::ADDR_CTRL0, 1, 32'h00);
    pulses(6);
    rd(clock_sysref_pkg::ADDR_POS0, 3, pos_coarse);
    check(32'(pos_coarse != pos_fine), 32'h1);
    // inverted sysref captures on the other pin edge
    wr(clock_sysref_pkg::ADDR_CTRL0, 1, 32'h10);
    wr(clock_sysref_pkg::ADDR_CTRL1, 1, 32'h01);
    pulses(6);
    rd(clock_sysref_pkg::ADDR_POS0, 3, q);
    check(32'(q != pos_fine), 32'h1);
    // host picks delay select from the position, receiver before processor
    wr(clock_sysref_pkg::ADDR_CTRL0, 1, {24'h0, 4'h2, pos_fine[3:0]});
    wr(clock_sysref_pkg::ADDR_CTRL0, 1, {24'h0, 4'h6, pos_fine[3:0]});
    check(32'({proc_en, recv_en, delay_sel}), {26'h0, 2'b11, pos_fine[3:0]});
    // mid-run reset brings the bank back to its reset values
    i_sys_rst = 1'b1;
    wait_clk(2);
    i_sys_rst = 1'b0;
    wait_clk(4);
    check(32'({gain_high, noise_sup, clk_delay}), 32'h9);
    check(32'({fs_a, fs_b}), 32'ha000a000);
    check(32'({proc_en, recv_en, delay_sel, devclk_dc, sysref_dc}), 32'h0);
    end_of_test();
  end
endmodule
